// ---- fpnav_top.sv ----
// Purpose: Front panel key handling, window navigation and bus status
// Assumes: Keys synchronous and high while pressed; poller reports
//   each finished poll with channel, address, register and outcome
// Notes on behaviour
// - A key is short when released quickly, long when held over 2 s.
// - Two or more keys held together produce no action at all.
// - At power on the normal display shows the last stored window.
// - Long confirm toggles between normal view and configuration menu.
// - Short up or down steps the window back or forth within 1 to 10.
// - Long up or down toggles timer driven stepping to the next window.
// - Automatic stepping shows a yellow footer indication.
// - The automatic step interval is settable and defaults to 5 s.
// - A bus communication error turns the bus indicator red at once.
// - A response timeout and a slave exception both count as errors.
// - The block keeps running while an error is shown.
// - Short confirm during an error opens the 32 channel table.
// - Each failing channel carries an error mark after its entry.
// - The shown table refreshes once a second.
// - The table only opens while an error is present.
// - Window number goes in the header; at most 12 elements a window.
`timescale 1ns/100ps
module fpnav_top
  import fpnav_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned LONG_CYC = LONG_PRESS_CYC,
  parameter int unsigned SEC_CYCLES = SEC_CYC,
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Keys, high while pressed
  input wire logic [2:0] key_in,
  // Persisted settings
  input wire logic [3:0] last_window,
  input wire logic [7:0] auto_interval_s,
  input wire logic auto_interval_set,
  input wire logic [3:0] elem_count,
  // Bus poller results
  input wire logic poll_done,
  input wire logic [4:0] poll_chan,
  input wire logic [7:0] poll_addr,
  input wire logic [15:0] poll_reg,
  input wire logic poll_timeout,
  input wire logic poll_exception,
  // Display state
  output logic [3:0] window_num,
  output logic [3:0] window_elems,
  output logic [1:0] mode,
  output logic autoscroll_on,
  output logic [1:0] autoscroll_color,
  output logic [1:0] bus_comm_status_indicator,
  output logic window_store,
  // Diagnostic table stream
  output logic diag_valid,
  output logic diag_first,
  output logic [4:0] diag_chan,
  output logic [7:0] diag_addr,
  output logic [15:0] diag_reg,
  output logic diag_err
);
  // ==========================================================
  // Keys
  // ==========================================================
  logic [2:0] sp, lp, held;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_key
      fpnav_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_key (
        .clk_sys(clk_sys),
        .rst(rst),
        .key_raw(key_in[gi]),
        .short_press(sp[gi]),
        .long_press(lp[gi]),
        .pressed(held[gi])
      );
    end
  endgenerate

  // Any overlap poisons the actuation until all keys are released
  // Cleared a cycle late: release events trail the held level
  logic combo_q;
  logic [2:0] held_q;
  logic single_ok;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      combo_q <= 1'b0;
      held_q <= 3'b000;
    end else begin
      held_q <= held;
      if (held == 3'b000) begin
        if (held_q == 3'b000) begin
          combo_q <= 1'b0;
        end
      end else if (held != 3'b001 && held != 3'b010 && held != 3'b100) begin
        combo_q <= 1'b1;
      end
    end
  end
  assign single_ok = !combo_q && (held == 3'b000 || held == 3'b001 ||
                     held == 3'b010 || held == 3'b100);

  logic up_s, dn_s, set_s, up_l, dn_l, set_l;
  assign up_s = sp[KEY_UP] && single_ok;
  assign dn_s = sp[KEY_DOWN] && single_ok;
  assign set_s = sp[KEY_SET] && single_ok;
  assign up_l = lp[KEY_UP] && single_ok;
  assign dn_l = lp[KEY_DOWN] && single_ok;
  assign set_l = lp[KEY_SET] && single_ok;

  // ==========================================================
  // Error state
  // ==========================================================
  logic [NUM_CH-1:0] err_ch_q;
  logic poll_err;
  assign poll_err = poll_timeout || poll_exception;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_ch_q <= '0;
    end else if (poll_done) begin
      err_ch_q[poll_chan] <= poll_err;
    end
  end

  // Operation never blocks on an error; only the flag changes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_comm_status_indicator <= COL_GREEN;
    end else if (poll_done && poll_err) begin
      bus_comm_status_indicator <= COL_RED;
    end else if ((err_ch_q & ~({{(NUM_CH-1){1'b0}}, 1'b1} << poll_chan))
                 == '0 && poll_done) begin
      bus_comm_status_indicator <= COL_GREEN;
    end
  end

  logic err_now;
  assign err_now = bus_comm_status_indicator == COL_RED;

  // ==========================================================
  // Mode
  // ==========================================================
  fpnav_mode_t mode_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= FPNAV_NORMAL;
    end else begin
      case (mode_q)
        FPNAV_NORMAL: begin
          if (set_l) begin
            mode_q <= FPNAV_CONFIG;
          end else if (set_s && err_now) begin
            mode_q <= FPNAV_DIAG;
          end
        end
        FPNAV_CONFIG: begin
          if (set_l) begin
            mode_q <= FPNAV_NORMAL;
          end
        end
        FPNAV_DIAG: begin
          if (set_s || set_l) begin
            mode_q <= FPNAV_NORMAL;
          end
        end
        default: mode_q <= FPNAV_NORMAL;
      endcase
    end
  end
  assign mode = mode_q;

  // ==========================================================
  // Autoscroll interval and timer
  // ==========================================================
  logic [7:0] interval_q;
  logic auto_q;
  logic [31:0] sec_cnt_q;
  logic [7:0] sec_q;
  logic auto_tick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      interval_q <= AUTO_INT_RESET;
    end else if (auto_interval_set && auto_interval_s != 8'h00) begin
      interval_q <= auto_interval_s;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      auto_q <= 1'b0;
    end else if (mode_q == FPNAV_NORMAL && (up_l || dn_l)) begin
      auto_q <= !auto_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sec_cnt_q <= '0;
      sec_q <= 8'h00;
    end else if (!auto_q || auto_tick) begin
      sec_cnt_q <= '0;
      sec_q <= 8'h00;
    end else if (sec_cnt_q >= SEC_CYCLES - 1) begin
      sec_cnt_q <= '0;
      sec_q <= sec_q + 8'h01;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end
  // Tick on the last cycle of the interval, so a step is exact
  assign auto_tick = auto_q && sec_cnt_q >= SEC_CYCLES - 1
                     && sec_q + 8'h01 >= interval_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      autoscroll_on <= 1'b0;
      autoscroll_color <= COL_BLACK;
    end else begin
      autoscroll_on <= auto_q;
      autoscroll_color <= auto_q ? COL_YELLOW : COL_BLACK;
    end
  end

  // ==========================================================
  // Window number
  // ==========================================================
  logic [3:0] win_q;
  logic win_init_q;
  logic nxt, prv;
  assign nxt = mode_q == FPNAV_NORMAL && (dn_s || auto_tick);
  assign prv = mode_q == FPNAV_NORMAL && up_s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      win_q <= WIN_FIRST;
      win_init_q <= 1'b0;
      window_store <= 1'b0;
    end else begin
      window_store <= 1'b0;
      if (!win_init_q) begin
        win_init_q <= 1'b1;
        if (last_window >= WIN_FIRST && last_window <= WIN_LAST) begin
          win_q <= last_window;
        end
      end else if (nxt) begin
        win_q <= (win_q == WIN_LAST) ? WIN_FIRST : win_q + 4'h1;
        window_store <= 1'b1;
      end else if (prv) begin
        win_q <= (win_q == WIN_FIRST) ? WIN_LAST : win_q - 4'h1;
        window_store <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      window_num <= WIN_FIRST;
      window_elems <= 4'h0;
    end else begin
      window_num <= win_q;
      window_elems <= (elem_count > 4'(MAX_ELEM)) ? 4'(MAX_ELEM)
                      : elem_count;
    end
  end

  // ==========================================================
  // Diagnostic table
  // ==========================================================
  logic [4:0] rd_ptr_q;
  logic scan_q, rd_v_q, first_q;
  logic [4:0] row_ptr_q;
  logic [31:0] ref_cnt_q;
  logic [23:0] rd_data;
  logic in_diag;
  assign in_diag = mode_q == FPNAV_DIAG;

  fpnav_chan_mem #(.DEPTH(NUM_CH), .AW(5), .DW(24)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(poll_done),
    .wr_addr(poll_chan),
    .wr_data({poll_addr, poll_reg}),
    .rd_addr(rd_ptr_q),
    .rd_data(rd_data)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_cnt_q <= '0;
      scan_q <= 1'b0;
      rd_ptr_q <= 5'h00;
    end else if (!in_diag) begin
      ref_cnt_q <= '0;
      scan_q <= 1'b0;
      rd_ptr_q <= 5'h00;
    end else begin
      if (ref_cnt_q == '0) begin
        scan_q <= 1'b1;
        rd_ptr_q <= 5'h00;
      end else if (scan_q) begin
        if (rd_ptr_q == 5'(NUM_CH - 1)) begin
          scan_q <= 1'b0;
        end else begin
          rd_ptr_q <= rd_ptr_q + 5'h01;
        end
      end
      ref_cnt_q <= (ref_cnt_q >= REFRESH_CYCLES - 1) ? '0
                   : ref_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_v_q <= 1'b0;
      row_ptr_q <= 5'h00;
      first_q <= 1'b0;
      diag_valid <= 1'b0;
      diag_first <= 1'b0;
      diag_chan <= 5'h00;
      diag_addr <= 8'h00;
      diag_reg <= 16'h0000;
      diag_err <= 1'b0;
    end else begin
      rd_v_q <= scan_q && in_diag;
      // Pointer delayed to line up with the registered read data
      row_ptr_q <= rd_ptr_q;
      first_q <= scan_q && in_diag && rd_ptr_q == 5'h00;
      diag_valid <= rd_v_q && in_diag;
      diag_first <= first_q && in_diag;
      if (rd_v_q) begin
        diag_chan <= row_ptr_q;
        diag_addr <= rd_data[23:16];
        diag_reg <= rd_data[15:0];
        diag_err <= err_ch_q[row_ptr_q];
      end
    end
  end
endmodule

// ---- fpnav_pkg.sv ----
// Purpose: Shared constants for the front panel window navigation block
// Assumes: 25 MHz system clock
// Notes: Times are kept in their own units, cycle counts derived here
package fpnav_pkg;
  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned LONG_PRESS_MS = 2000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned AUTO_STEP_S = 5;
  localparam int unsigned REFRESH_MS = 1000;
  localparam int unsigned LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned REFRESH_CYC = CLK_HZ / 1000 * REFRESH_MS;
  localparam int unsigned SEC_CYC = CLK_HZ;

  // ==========================================================
  // Windows, channels, display
  // ==========================================================
  localparam int unsigned NUM_WIN = 10;
  localparam int unsigned NUM_CH = 32;
  localparam int unsigned MAX_ELEM = 12;
  localparam logic [3:0] WIN_FIRST = 4'h1;
  localparam logic [3:0] WIN_LAST = 4'ha;
  localparam logic [7:0] AUTO_INT_RESET = 8'h05;

  // Key indices
  localparam int unsigned KEY_UP = 0;
  localparam int unsigned KEY_DOWN = 1;
  localparam int unsigned KEY_SET = 2;

  // Indicator colours
  localparam logic [1:0] COL_BLACK = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_RED = 2'h2;
  localparam logic [1:0] COL_YELLOW = 2'h3;

  typedef enum logic [1:0] {
    FPNAV_NORMAL = 2'b00,
    FPNAV_CONFIG = 2'b01,
    FPNAV_DIAG = 2'b10
  } fpnav_mode_t;
endpackage

// ---- fpnav_key.sv ----
// Purpose: Debounce one key and classify short and long presses
// Assumes: Key input synchronous to clk_sys, high while pressed
// Notes: Long press fires once at threshold; release then gives nothing
`timescale 1ns/100ps
module fpnav_key
  import fpnav_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Key
  input wire logic key_raw,
  // Events
  output logic short_press,
  output logic long_press,
  output logic pressed
);
  // ==========================================================
  // Debounce
  // ==========================================================
  logic [31:0] deb_cnt_q;
  logic stable_q;
  logic [31:0] hold_cnt_q;
  logic long_done_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deb_cnt_q <= '0;
      stable_q <= 1'b0;
    end else if (key_raw == stable_q) begin
      deb_cnt_q <= '0;
    end else if (deb_cnt_q >= DEB_CYC - 1) begin
      deb_cnt_q <= '0;
      stable_q <= key_raw;
    end else begin
      deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // Press classification
  // ==========================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= '0;
      long_done_q <= 1'b0;
      short_press <= 1'b0;
      long_press <= 1'b0;
    end else begin
      short_press <= 1'b0;
      long_press <= 1'b0;
      if (stable_q) begin
        if (!long_done_q) begin
          if (hold_cnt_q >= LONG_CYC - 1) begin
            long_press <= 1'b1;
            long_done_q <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
          end
        end
      end else begin
        if (hold_cnt_q != '0 && !long_done_q) begin
          short_press <= 1'b1;
        end
        hold_cnt_q <= '0;
        long_done_q <= 1'b0;
      end
    end
  end

  assign pressed = stable_q;
endmodule

// ---- fpnav_chan_mem.sv ----
// Purpose: Per-channel table of slave address and register
// Assumes: One write and one read port, read data registered
// Notes: An entry keeps its value until its channel is written again
`timescale 1ns/100ps
module fpnav_chan_mem
  import fpnav_pkg::*;
#(
  parameter int unsigned DEPTH = NUM_CH,
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 25
) (
  // Clock
  input wire logic clk_sys,
  // Write
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem_q[rd_addr];
  end
endmodule

// ---- fpnav_monitor.sv ----
// Purpose: Port checker for fpnav_top
// Assumes: One clock domain, bound to the design top
// Notes: Table row order and refresh spacing judged at the ports
`timescale 1ns/100ps
module fpnav_monitor
  import fpnav_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs watched
  input wire logic [2:0] key_in,
  input wire logic poll_done,
  input wire logic poll_timeout,
  input wire logic poll_exception,
  // Display state
  input wire logic [3:0] window_num,
  input wire logic [3:0] window_elems,
  input wire logic [1:0] mode,
  input wire logic autoscroll_on,
  input wire logic [1:0] autoscroll_color,
  input wire logic [1:0] bus_comm_status_indicator,
  input wire logic window_store,
  // Table stream
  input wire logic diag_valid,
  input wire logic diag_first,
  input wire logic [4:0] diag_chan
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] gap_q;
  logic seen_q;
  // ==========================================================
  // Refresh spacing helpers
  // ==========================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_q <= 32'h0;
    end else if (diag_valid && diag_first) begin
      gap_q <= 32'h0;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  // First scan after entry has no earlier start to measure from
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= (mode == FPNAV_DIAG) && (seen_q || (diag_valid && diag_first));
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  sequence s_enter_diag;
    $rose(mode == FPNAV_DIAG);
  endsequence
  sequence s_first_row;
    diag_valid && diag_first && diag_chan == 5'h00;
  endsequence
  a_red_on_error: assert property (
    poll_done && (poll_timeout || poll_exception)
    |=> bus_comm_status_indicator == COL_RED) else $error("no red");
  a_footer_color: assert property (
    autoscroll_color == (autoscroll_on ? COL_YELLOW : COL_BLACK))
    else $error("footer colour");
  a_window_range: assert property (
    window_num >= WIN_FIRST && window_num <= WIN_LAST) else $error("win");
  a_elem_limit: assert property (
    window_elems <= 4'hc) else $error("too many elements");
  a_table_gate: assert property (
    s_enter_diag |-> $past(bus_comm_status_indicator) == COL_RED)
    else $error("table without error");
  a_table_start: assert property (
    s_enter_diag |-> ##3 s_first_row) else $error("table start");
  a_row_order: assert property (
    mode == FPNAV_DIAG && diag_valid && diag_chan != 5'h1f
    |=> mode != FPNAV_DIAG
    || (diag_valid && diag_chan == $past(diag_chan) + 5'h1))
    else $error("row order");
  a_refresh_gap: assert property (
    seen_q && diag_valid && diag_first |-> gap_q == REFRESH_CYCLES - 1)
    else $error("refresh period");
  a_config_by_set: assert property (
    mode == FPNAV_CONFIG && $past(mode) == FPNAV_NORMAL
    |-> $past(key_in, 2) == 3'b100) else $error("config entry");
  a_store_change: assert property (
    window_store |=> window_num != $past(window_num))
    else $error("store without window change");
endmodule

bind fpnav_top fpnav_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .key_in(key_in), .poll_done(poll_done),
  .poll_timeout(poll_timeout), .poll_exception(poll_exception),
  .window_num(window_num), .window_elems(window_elems), .mode(mode),
  .autoscroll_on(autoscroll_on), .autoscroll_color(autoscroll_color),
  .bus_comm_status_indicator(bus_comm_status_indicator),
  .window_store(window_store),
  .diag_valid(diag_valid), .diag_first(diag_first), .diag_chan(diag_chan)
);

// ---- fpnav_panel_model.sv ----
// Purpose: Operator keypad and bus poller seen from the block
// Assumes: Driven on rising clock edges
// Notes: Key presses start with contact bounce
`timescale 1ns/100ps
module fpnav_panel_model
  import fpnav_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Keypad
  output logic [2:0] key_in,
  // Poller results
  output logic poll_done,
  output logic [4:0] poll_chan,
  output logic [7:0] poll_addr,
  output logic [15:0] poll_reg,
  output logic poll_timeout,
  output logic poll_exception
);
  initial begin
    key_in = 3'h0;
    poll_done = 1'b0;
    {poll_chan, poll_addr, poll_reg} = '0;
    {poll_timeout, poll_exception} = 2'h0;
  end
  // Glitches shorter than the debounce time precede the stable level
  task automatic press(input logic [2:0] k, input int hold);
    repeat (2) begin
      @(posedge clk_sys) key_in <= k;
      @(posedge clk_sys) key_in <= 3'h0;
    end
    @(posedge clk_sys) key_in <= k;
    repeat (hold) @(posedge clk_sys);
    key_in <= 3'h0;
    repeat (12) @(posedge clk_sys);
  endtask
  // Fields are inverted outside the valid cycle, never left standing
  task automatic poll(input logic [4:0] c, input logic [7:0] a,
                      input logic [15:0] r, input logic t, input logic e);
    @(posedge clk_sys);
    poll_done <= 1'b1;
    {poll_chan, poll_addr, poll_reg, poll_timeout, poll_exception}
      <= {c, a, r, t, e};
    @(posedge clk_sys);
    poll_done <= 1'b0;
    {poll_chan, poll_addr, poll_reg, poll_timeout, poll_exception}
      <= ~{c, a, r, t, e};
  endtask
endmodule

// ---- fpnav_top_tb.sv ----
// Purpose: Self-checking bench for fpnav_top
// Assumes: Short counts: 4 debounce, 50 long, 10 per second
// Notes: Table rows are read from a refresh scan, not the first
`timescale 1ns/100ps
module fpnav_top_tb;
  import fpnav_pkg::*;
  localparam int unsigned SEC = 10;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] last_window = 4'h7;
  logic [7:0] auto_interval_s = 8'h00;
  logic auto_interval_set = 1'b0;
  logic [3:0] elem_count = 4'hf;
  logic [2:0] key_in;
  logic poll_done, poll_timeout, poll_exception;
  logic [4:0] poll_chan, diag_chan;
  logic [7:0] poll_addr, diag_addr;
  logic [15:0] poll_reg, diag_reg;
  logic [3:0] window_num, window_elems;
  logic [1:0] mode, autoscroll_color, bus_ind;
  logic autoscroll_on, window_store, diag_valid, diag_first, diag_err;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  fpnav_top #(.DEB_CYC(4), .LONG_CYC(50), .SEC_CYCLES(SEC),
    .REFRESH_CYCLES(100)) dut (
    .clk_sys(clk_sys), .rst(rst), .key_in(key_in),
    .last_window(last_window), .auto_interval_s(auto_interval_s),
    .auto_interval_set(auto_interval_set), .elem_count(elem_count),
    .poll_done(poll_done), .poll_chan(poll_chan), .poll_addr(poll_addr),
    .poll_reg(poll_reg), .poll_timeout(poll_timeout),
    .poll_exception(poll_exception), .window_num(window_num),
    .window_elems(window_elems), .mode(mode), .autoscroll_on(autoscroll_on),
    .autoscroll_color(autoscroll_color), .bus_comm_status_indicator(bus_ind),
    .window_store(window_store), .diag_valid(diag_valid),
    .diag_first(diag_first), .diag_chan(diag_chan), .diag_addr(diag_addr),
    .diag_reg(diag_reg), .diag_err(diag_err));
  fpnav_panel_model model (
    .clk_sys(clk_sys), .key_in(key_in), .poll_done(poll_done),
    .poll_chan(poll_chan), .poll_addr(poll_addr), .poll_reg(poll_reg),
    .poll_timeout(poll_timeout), .poll_exception(poll_exception));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Sampling on the falling edge keeps clear of the design's updates
  task automatic wait_step(output int n);
    logic [3:0] w;
    w = window_num;
    n = 0;
    while (window_num === w && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  function automatic logic [7:0] adr(input int c);
    return 8'h10 + c[7:0];
  endfunction
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power_on;
    repeat (3) @(negedge clk_sys);
    chk(window_num, 4'h7);
    chk(window_elems, 4'hc);
  endtask
  task automatic t_manual;
    logic [2:0] k[5] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h1};
    logic [3:0] w[5] = '{4'h8, 4'h9, 4'ha, 4'h1, 4'ha};
    for (int i = 0; i < 5; i++) begin
      model.press(k[i], 10);
      chk(window_num, w[i]);
    end
  endtask
  task automatic t_combo;
    model.press(3'h3, 10);
    chk(window_num, 4'ha);
    model.press(3'h6, 70);
    chk({mode, autoscroll_on}, {FPNAV_NORMAL, 1'b0});
  endtask
  task automatic t_config;
    model.press(3'h4, 70);
    chk(mode, FPNAV_CONFIG);
    model.press(3'h2, 10);
    chk(window_num, 4'ha);
    model.press(3'h4, 70);
    chk(mode, FPNAV_NORMAL);
  endtask
  task automatic t_auto;
    int n;
    logic [3:0] w;
    model.press(3'h2, 70);
    chk({autoscroll_on, autoscroll_color}, {1'b1, COL_YELLOW});
    wait_step(n);
    wait_step(n);
    chk(n, SEC * AUTO_INT_RESET);
    @(posedge clk_sys);
    auto_interval_s <= 8'h02;
    auto_interval_set <= 1'b1;
    @(posedge clk_sys);
    auto_interval_set <= 1'b0;
    wait_step(n);
    wait_step(n);
    chk(n, SEC * 2);
    model.press(3'h1, 70);
    chk({autoscroll_on, autoscroll_color}, {1'b0, COL_BLACK});
    w = window_num;
    repeat (60) @(negedge clk_sys);
    chk(window_num, w);
  endtask
  task automatic t_bus;
    int j;
    logic [3:0] w;
    model.press(3'h4, 10);
    chk(mode, FPNAV_NORMAL);
    for (int i = 0; i < 32; i++) begin
      model.poll(i[4:0], adr(i), 16'ha500 + i[15:0], 1'b0, 1'b0);
    end
    model.poll(5'h03, adr(3), 16'ha503, 1'b1, 1'b0);
    @(negedge clk_sys);
    chk(bus_ind, COL_RED);
    model.poll(5'h05, adr(5), 16'ha505, 1'b0, 1'b1);
    w = window_num;
    model.press(3'h2, 10);
    chk({bus_ind, window_num}, {COL_RED, w == 4'ha ? 4'h1 : w + 4'h1});
    model.press(3'h4, 10);
    chk(mode, FPNAV_DIAG);
    j = 0;
    while (!(diag_valid === 1'b1 && diag_first === 1'b1) && j < 150) begin
      @(negedge clk_sys);
      j++;
    end
    chk(j < 150, 1'b1);
    for (int i = 0; i < 32; i++) begin
      chk({diag_valid, diag_chan}, {1'b1, i[4:0]});
      chk({diag_addr, diag_reg}, {adr(i), 16'ha500 + i[15:0]});
      chk(diag_err, i == 3 || i == 5);
      @(negedge clk_sys);
    end
    model.press(3'h4, 10);
    chk(mode, FPNAV_NORMAL);
    model.poll(5'h03, adr(3), 16'ha503, 1'b0, 1'b0);
    model.poll(5'h05, adr(5), 16'ha505, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk(bus_ind, COL_GREEN);
  endtask
  // ==========================================================
  // Main sequence and hang guard
  // ==========================================================
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_on;
    t_manual;
    t_combo;
    t_config;
    t_auto;
    t_bus;
    end_sim;
  end
endmodule
